// >>> irqdc_cfg.svh
// register offsets, field positions, reset values and timing for the interrupt output stage
// assumes inclusion by irqdc_top.sv; irqdc_pkg.sv does not include it
`ifndef IRQDC_CFG_SVH
`define IRQDC_CFG_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define IRQDC_PIN_CFG_OFF 8'h54
`define IRQDC_SRC_STS_OFF 8'h58
`define IRQDC_SRC_EN_OFF 8'h5c
`define IRQDC_EVT_STS_OFF 8'h60
`define IRQDC_EVT_MASK_OFF 8'h64

// ------------------------------------------------------------
// interrupt_pin_config fields and reset word, plus the power management event source status bit
// ------------------------------------------------------------
`define IRQDC_DEAS_HI 31
`define IRQDC_DEAS_LO 24
`define IRQDC_RESTART_BIT 14
`define IRQDC_ACTIVE_BIT 13
`define IRQDC_MASTER_BIT 12
`define IRQDC_PIN_EN_BIT 8
`define IRQDC_POL_BIT 4
`define IRQDC_TYPE_BIT 0
`define IRQDC_PME_BIT 17
`define IRQDC_RESET_WORD 32'h0000_0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IRQDC_CLK_HZ 25000000
`define IRQDC_TICK_NS 10000
`define IRQDC_TICK_CYC ((`IRQDC_CLK_HZ / 1000) * `IRQDC_TICK_NS / 1000000)

// own event status bits
`define IRQDC_EVT_RAISE 0
`define IRQDC_EVT_EXPIRE 1

`endif

// >>> irqdc_pkg.sv
// types shared by the interrupt output stage
// assumes irqdc_cfg.svh is on the include path
package irqdc_pkg;
    typedef enum logic [1:0] {
        IRQDC_RESP_OKAY = 2'h0,
        IRQDC_RESP_SLVERR = 2'h2
    } irqdc_resp_t;
endpackage

// >>> irqdc_top.sv
// interrupt output stage: source status/enable, master line, deassertion interval, pin driver
// assumes an axi4-lite master on aclk and a host interrupt input on the far side of irq pin
//
// Functional notes
// RULE1 - 8-bit deassert interval at bits 31:24, units of 10 us
// RULE2 - writing zero stops timing, clears counter, releases pending interrupts at once
// RULE3 - a new non-zero interval governs every later interrupt
// RULE4 - power management event interrupt is never withheld by the interval
// RULE5 - self-clearing restart bit 14 clears counter and starts a fresh interval
// RULE6 - bit 13 reads one during an interval; enabled interrupts then withheld
// RULE7 - bit 12 mirrors master line, ignoring pin enable and interval
// RULE8 - pin enable bit 8 low keeps pin inactive; status bits unaffected
// RULE9 - polarity bit 4: zero active low, one active high, push-pull only
// RULE10 - type bit 0: zero open-drain always active low, one push-pull
// RULE11 - writing one to a source status bit clears it, removing it from master line
// RULE12 - 10 us tick from clock; interval starts when pin returns inactive
`timescale 1ns/10ps
`default_nettype none
`include "irqdc_cfg.svh"

module irqdc_top #(
    parameter int unsigned TICK_CYC = `IRQDC_TICK_CYC,
    parameter int unsigned SRC_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SRC_W-1:0] src_event,
    output logic irq_pin_o,
    output logic irq_pin_oe,
    output logic evt_irq
);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic aw_held_q;
    logic [7:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_wr;
    logic [31:0] wmask;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    function automatic logic known(input logic [7:0] a);
        known = (a == `IRQDC_PIN_CFG_OFF) || (a == `IRQDC_SRC_STS_OFF) ||
                (a == `IRQDC_SRC_EN_OFF) || (a == `IRQDC_EVT_STS_OFF) ||
                (a == `IRQDC_EVT_MASK_OFF);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (do_wr) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= irqdc_pkg::IRQDC_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(aw_addr_q) ? irqdc_pkg::IRQDC_RESP_OKAY
                                            : irqdc_pkg::IRQDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // the strobe is an argument so the decode re-evaluates when it moves, not only the address
    function automatic logic hit(input logic en, input logic [7:0] off, input logic [7:0] a);
        hit = en && (a == off);
    endfunction

    logic wr_cfg, wr_sts, wr_en, wr_evt, wr_msk;
    assign wr_cfg = hit(do_wr, `IRQDC_PIN_CFG_OFF, aw_addr_q);
    assign wr_sts = hit(do_wr, `IRQDC_SRC_STS_OFF, aw_addr_q);
    assign wr_en = hit(do_wr, `IRQDC_SRC_EN_OFF, aw_addr_q);
    assign wr_evt = hit(do_wr, `IRQDC_EVT_STS_OFF, aw_addr_q);
    assign wr_msk = hit(do_wr, `IRQDC_EVT_MASK_OFF, aw_addr_q);

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    logic [7:0] deassert_interval_q;
    logic pin_en_q;
    logic irq_pin_polarity_q;
    logic push_pull_q;
    logic [SRC_W-1:0] src_en_q;
    logic deas_zero_wr;
    logic deassert_interval_restart;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deassert_interval_q <= 8'h00;
        end else if (wr_cfg && w_strb_q[3]) begin
            deassert_interval_q <= w_data_q[`IRQDC_DEAS_HI:`IRQDC_DEAS_LO]; // RULE1 RULE3
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_en_q <= 1'b0;
            irq_pin_polarity_q <= 1'b0;
            push_pull_q <= 1'b0;
        end else if (wr_cfg) begin
            if (w_strb_q[1]) begin
                pin_en_q <= w_data_q[`IRQDC_PIN_EN_BIT];
            end
            if (w_strb_q[0]) begin
                irq_pin_polarity_q <= w_data_q[`IRQDC_POL_BIT];
                push_pull_q <= w_data_q[`IRQDC_TYPE_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_en_q <= '0;
        end else if (wr_en) begin
            src_en_q <= (src_en_q & ~wmask[SRC_W-1:0]) | (w_data_q[SRC_W-1:0] & wmask[SRC_W-1:0]);
        end
    end

    assign deas_zero_wr = wr_cfg && w_strb_q[3] &&
                          (w_data_q[`IRQDC_DEAS_HI:`IRQDC_DEAS_LO] == 8'h00);
    // restart is a write strobe only, so the bit never holds a one
    assign deassert_interval_restart = wr_cfg && w_strb_q[1] &&
                                       w_data_q[`IRQDC_RESTART_BIT];

    // ------------------------------------------------------------
    // source status and master line
    // ------------------------------------------------------------
    logic [SRC_W-1:0] interrupt_source_status_q;
    logic [SRC_W-1:0] pend;
    logic master_line;
    logic pme_line;
    logic other_line;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_source_status_q <= '0;
        end else begin
            // a new event wins over a same-cycle acknowledge
            interrupt_source_status_q <= (interrupt_source_status_q &
                ~(wr_sts ? (w_data_q[SRC_W-1:0] & wmask[SRC_W-1:0]) : '0)) | src_event; // RULE11
        end
    end

    assign pend = interrupt_source_status_q & src_en_q;
    assign master_line = |pend; // RULE7
    assign pme_line = pend[`IRQDC_PME_BIT];
    assign other_line = |(pend & ~(SRC_W'(1) << `IRQDC_PME_BIT));

    // ------------------------------------------------------------
    // deassertion interval timer
    // ------------------------------------------------------------
    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    logic [TW-1:0] tick_cnt_q;
    logic tick;
    logic [7:0] units_q;
    logic deassert_interval_active_q;
    logic pin_act_q;
    logic pin_act_d;
    logic pin_fall;

    always_ff @(posedge aclk) begin
        if (!aresetn || !deassert_interval_active_q || deassert_interval_restart) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = deassert_interval_active_q && (tick_cnt_q == TW'(TICK_CYC - 1)); // RULE12

    assign pin_fall = pin_act_q && !pin_act_d;

    always_ff @(posedge aclk) begin
        if (!aresetn || deas_zero_wr) begin
            deassert_interval_active_q <= 1'b0; // RULE2
            units_q <= 8'h00;
        end else if (deassert_interval_q != 8'h00 &&
                     (deassert_interval_restart || pin_fall)) begin
            deassert_interval_active_q <= 1'b1; // RULE5 RULE12
            units_q <= 8'h00;
        end else if (tick) begin
            if (units_q + 8'h01 >= deassert_interval_q) begin
                deassert_interval_active_q <= 1'b0;
                units_q <= 8'h00;
            end else begin
                units_q <= units_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    always_comb begin
        pin_act_d = pin_en_q && (pme_line || // RULE4 RULE8
                    (other_line && !deassert_interval_active_q)); // RULE6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_act_q <= 1'b0;
            irq_pin_o <= 1'b0;
            irq_pin_oe <= 1'b0;
        end else begin
            pin_act_q <= pin_act_d;
            if (push_pull_q) begin
                irq_pin_o <= pin_act_d ~^ irq_pin_polarity_q; // RULE9
                irq_pin_oe <= 1'b1;
            end else begin
                irq_pin_o <= 1'b0; // RULE10
                irq_pin_oe <= pin_act_d;
            end
        end
    end

    // ------------------------------------------------------------
    // own events: pin raised, interval expired
    // ------------------------------------------------------------
    logic [1:0] evt_sts_q;
    logic [1:0] evt_msk_q;
    logic [1:0] evt_set;
    assign evt_set = {tick && (units_q + 8'h01 >= deassert_interval_q), pin_act_d && !pin_act_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_sts_q <= 2'h0;
        end else begin
            evt_sts_q <= (evt_sts_q & ~(wr_evt ? w_data_q[1:0] : 2'h0)) | evt_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_msk_q <= 2'h0;
        end else if (wr_msk && w_strb_q[0]) begin
            evt_msk_q <= w_data_q[1:0];
        end
    end
    assign evt_irq = |(evt_sts_q & evt_msk_q);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] cfg_word;
    always_comb begin
        cfg_word = `IRQDC_RESET_WORD;
        cfg_word[`IRQDC_DEAS_HI:`IRQDC_DEAS_LO] = deassert_interval_q;
        cfg_word[`IRQDC_ACTIVE_BIT] = deassert_interval_active_q;
        cfg_word[`IRQDC_MASTER_BIT] = master_line;
        cfg_word[`IRQDC_PIN_EN_BIT] = pin_en_q;
        cfg_word[`IRQDC_POL_BIT] = irq_pin_polarity_q;
        cfg_word[`IRQDC_TYPE_BIT] = push_pull_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= irqdc_pkg::IRQDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= irqdc_pkg::IRQDC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `IRQDC_PIN_CFG_OFF: s_axi_rdata <= cfg_word;
                `IRQDC_SRC_STS_OFF: s_axi_rdata <= 32'(interrupt_source_status_q);
                `IRQDC_SRC_EN_OFF: s_axi_rdata <= 32'(src_en_q);
                `IRQDC_EVT_STS_OFF: s_axi_rdata <= {30'h0, evt_sts_q};
                `IRQDC_EVT_MASK_OFF: s_axi_rdata <= {30'h0, evt_msk_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= irqdc_pkg::IRQDC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // irqdc_top
`default_nettype wire

// >>> irqdc_chk.sv
// checker: pin drive level, gap after release, bus response retirement
// assumes binding onto irqdc_top; one clock with synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module irqdc_chk #(
    parameter int unsigned SRC_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SRC_W-1:0] src_event,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe
);
    // ----------------
    // setup shadow
    // ----------------
    logic [31:0] cfg_q;
    logic [31:0] en_q;
    logic [1:0] stab_q;
    logic pin_act;
    logic calm;
    // active level is high only for push-pull with polarity set
    assign pin_act = irq_pin_oe && (irq_pin_o == (cfg_q[0] & cfg_q[4]));
    // the pin trails a setup write by a few edges, so judge it only once settled
    assign calm = stab_q == 2'h3;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= 32'h0000_0000;
            en_q <= 32'h0000_0000;
            stab_q <= 2'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
            if (s_axi_awaddr == 8'h54) begin
                cfg_q <= s_axi_wdata;
                stab_q <= 2'h0;
            end
            if (s_axi_awaddr == 8'h5c) begin
                en_q <= s_axi_wdata;
                stab_q <= 2'h0;
            end
        end else if (!calm) begin
            stab_q <= stab_q + 2'h1;
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_release;
        $fell(pin_act) && calm && cfg_q[31:24] != 8'h00;
    endsequence
    property p_rst_rel; $rose(aresetn) |-> !irq_pin_oe; endproperty
    property p_pin_off; calm && !cfg_q[8] |-> !pin_act; endproperty
    property p_od_low; calm && !cfg_q[0] |-> !irq_pin_o; endproperty
    property p_pp_drive; calm && cfg_q[0] |-> irq_pin_oe; endproperty
    property p_gap; s_release |=> !pin_act [*2]; endproperty
    property p_pme; calm && src_event[17] && en_q[17] && cfg_q[8] |-> ##[1:3] pin_act; endproperty
    property p_bhold; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_rhold; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("pin driven after reset");
    a_pin_off: assert property (p_pin_off) else $error("pin active while disabled");
    a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");
    a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin released");
    a_gap: assert property (p_gap) else $error("pin reasserted inside interval");
    a_pme: assert property (p_pme) else $error("power event held back");
    a_bhold: assert property (p_bhold) else $error("write response repeated");
    a_rhold: assert property (p_rhold) else $error("read response repeated");
endmodule // irqdc_chk
bind irqdc_top irqdc_chk #(.SRC_W(SRC_W)) i_chk (.*);
`default_nettype wire

// >>> irqdc_host.sv
// host interrupt input: wired line with pull-up, samples whether the request is active
// assumes the bench tells it which level the pin asserts with
`timescale 1ns/10ps
`default_nettype none
module irqdc_host (
    input wire logic aclk,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe,
    input wire logic active_high,
    output logic wire_level,
    output logic irq_seen
);
    // pull-up lets other open-drain sources share the line
    assign wire_level = irq_pin_oe ? irq_pin_o : 1'b1;
    always_ff @(posedge aclk) begin
        irq_seen <= wire_level == active_high;
    end
endmodule // irqdc_host
`default_nettype wire

// >>> tb_irq_output_deassert_control.sv
// bench for the interrupt output stage: pin modes, interval, events, bus errors
// assumes irqdc_top with a 4-cycle tick, the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_irq_output_deassert_control;
    // ----------------
    // signals and instances
    // ----------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    logic [31:0] src_event = 32'h0000_0000;
    logic irq_pin_o;
    logic irq_pin_oe;
    logic evt_irq;
    logic active_high = 1'b0;
    logic wire_level;
    logic irq_seen;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    // expected {seen, oe, o} above each setup word
    logic [34:0] rows [5] = '{35'h6_0000_0100, 35'h6_0000_0101, 35'h7_0000_0111,
        35'h6_0000_0110, 35'h3_0000_0001};
    irqdc_top #(.TICK_CYC(4)) i_dut (.s_axi_wstrb(4'hf), .*);
    irqdc_host i_host (.*);
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // bready and rready stay high, so each response is taken at the first edge it shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        check(s_axi_rdata, e);
        check(s_axi_rresp, er);
    endtask
    task automatic pulse(input int b);
        src_event <= 32'h0000_0001 << b;
        @(posedge aclk);
        src_event <= 32'h0000_0000;
    endtask
    // ----------------
    // sequence
    // ----------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(8'h5c, 32'h0002_0008, 2'h0);
        foreach (rows[i]) begin
            active_high <= rows[i][0] & rows[i][4];
            wr(8'h54, rows[i][31:0], 2'h0);
            pulse(3);
            repeat (4) @(posedge aclk);
            check({irq_seen, irq_pin_oe, irq_pin_o}, rows[i][34:32]);
            rd(8'h54, rows[i][31:0] | 32'h0000_1000, 2'h0);
            wr(8'h58, 32'h0000_0008, 2'h0);
            repeat (4) @(posedge aclk);
            check(irq_seen, 1'b0);
        end
        wr(8'h54, 32'h0300_0101, 2'h0);
        pulse(3);
        repeat (4) @(posedge aclk);
        check(irq_seen, 1'b1);
        wr(8'h58, 32'h0000_0008, 2'h0);
        pulse(3);
        repeat (2) @(posedge aclk);
        rd(8'h54, 32'h0300_3101, 2'h0);
        check(irq_seen, 1'b0);
        repeat (12) @(posedge aclk);
        check(irq_seen, 1'b1);
        wr(8'h58, 32'h0000_0008, 2'h0);
        repeat (3) @(posedge aclk);
        pulse(17);
        repeat (4) @(posedge aclk);
        check(irq_seen, 1'b1);
        wr(8'h58, 32'h0002_0000, 2'h0);
        repeat (16) @(posedge aclk);
        wr(8'h54, 32'hff00_0101, 2'h0);
        pulse(3);
        repeat (4) @(posedge aclk);
        wr(8'h58, 32'h0000_0008, 2'h0);
        pulse(3);
        repeat (20) @(posedge aclk);
        check(irq_seen, 1'b0);
        wr(8'h54, 32'hff00_4101, 2'h0);
        rd(8'h54, 32'hff00_3101, 2'h0);
        wr(8'h54, 32'h0000_0101, 2'h0);
        repeat (4) @(posedge aclk);
        check(irq_seen, 1'b1);
        // a restart late in an interval must push the release out by a whole interval
        wr(8'h54, 32'h0300_0101, 2'h0);
        wr(8'h58, 32'h0000_0008, 2'h0);
        pulse(3);
        repeat (4) @(posedge aclk);
        wr(8'h54, 32'h0300_4101, 2'h0);
        repeat (8) @(posedge aclk);
        check(irq_seen, 1'b0);
        repeat (8) @(posedge aclk);
        check(irq_seen, 1'b1);
        wr(8'h58, 32'h0000_0008, 2'h0);
        check(evt_irq, 1'b0);
        rd(8'h60, 32'h0000_0003, 2'h0);
        wr(8'h64, 32'h0000_0003, 2'h0);
        check(evt_irq, 1'b1);
        wr(8'h60, 32'h0000_0003, 2'h0);
        check(evt_irq, 1'b0);
        wr(8'h64, 32'h0000_0000, 2'h0);
        wr(8'h80, 32'hffff_ffff, 2'h2);
        rd(8'h80, 32'h0000_0000, 2'h2);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(irq_pin_oe, 1'b0);
        rd(8'h54, 32'h0000_0000, 2'h0);
        complete_run();
    end
endmodule // tb_irq_output_deassert_control
`default_nettype wire
